// >>> rtl/ekst_pkg.sv
// ephemeral key tracker: shared constants and types
package ekst_pkg;
    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int KEY_W  = 256;
    localparam int IDX_W  = 16;
    localparam int SLOT_W = 4;
    localparam int ROLL_W = 8;
    localparam int ROLL_N = 8;
    localparam int ADDR_W = 8;
    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CTRL   = 8'h04;
    localparam logic [7:0] OFS_ROLL0  = 8'h08;
    localparam logic [7:0] OFS_ROLL7  = 8'h24;
    // ----------------------------------------
    // field positions of the status word
    // ----------------------------------------
    localparam int ST_VALID = 0;
    localparam int ST_SRC   = 1;
    localparam int ST_ORIG  = 2;
    localparam int ST_RESTR = 3;
    localparam int ST_SLOT  = 4;
    // control word: random inclusion enable
    localparam int CT_RAND  = 0;
    // policy word: encrypted write enable
    localparam int POL_WR   = 14;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [7:0]  ROLL_RST = 8'h00;
    // command codes
    typedef enum logic [2:0] {
        EKST_SEED    = 3'b000,
        EKST_DIGEST  = 3'b001,
        EKST_COMPARE = 3'b010,
        EKST_DERIVE  = 3'b011,
        EKST_OTHER   = 3'b100
    } ekst_cmd_code_t;
    // one finished command from the command engine
    typedef struct packed {
        logic                done;
        ekst_cmd_code_t      code;
        logic                ok;
        logic                crc_err;
        logic                copy_ok;
        logic                use_rand;
        logic                restricted;
        logic                roll;
        logic [IDX_W-1:0]    key_idx;
        logic [KEY_W-1:0]    data;
    } ekst_cmd_t;
    // device power and safety events
    typedef struct packed {
        logic sleep;
        logic brownout;
        logic wdog;
        logic tamper;
        logic idle;
    } ekst_evt_t;
    // plain register port request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } ekst_bus_t;
endpackage

// >>> rtl/ekst_tracker.sv
// ephemeral key register, its status fields and related helpers
`timescale 1ns/100ps
// Behaviour
// [R1] hold 256-bit key from seed or digest
// [R2] key never readable over register port
// [R3] store 4-bit slot index on digest
// [R4] randomness flag: 0 random, 1 input only
// [R5] slot-origin flag set only by digest
// [R6] compare-restricted flag only from restricted digest
// [R7] validity bit marks key usable
// [R8] power, sleep, faults clear valid; idle keeps
// [R9] other commands clear valid, ok or not
// [R10] compare keeps valid on successful copy
// [R11] checksum-rejected command leaves valid alone
// [R12] seed or digest error clears valid
// [R13] seed and digest overwrite each other
// [R14] seed is challenge, optionally mixed with random
// [R15] responses are 256-bit digests
// [R16] crypt by xor of digest and text
// [R17] keys are 256 bits in hashes
// [R18] slot select uses low four index bits
// [R19] full 16-bit index goes into hash
// [R20] host runs seed before key roll
// [R21] roll on slots 0-7 bumps counter
// [R22] encrypted write needs policy bit 14
// [R23] sleep or power loss invalidates key
// [R24] key absent whenever valid is 0
module ekst_tracker (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_b,
    input  wire ekst_pkg::ekst_bus_t         bus,
    output logic [31:0]                      rdata,
    input  wire ekst_pkg::ekst_cmd_t         cmd,
    input  wire logic [ekst_pkg::KEY_W-1:0]  rand_num,
    input  wire ekst_pkg::ekst_evt_t         evt,
    input  wire logic                        crypt_req,
    input  wire logic [ekst_pkg::KEY_W-1:0]  crypt_pad,
    input  wire logic [ekst_pkg::KEY_W-1:0]  crypt_text,
    input  wire logic                        wr_req,
    input  wire logic [15:0]                 slot_policy_word,
    output logic [ekst_pkg::KEY_W-1:0]       ephemeral_key_out,
    output logic                             key_present,
    output logic [ekst_pkg::KEY_W-1:0]       crypt_out,
    output logic [ekst_pkg::SLOT_W-1:0]      slot_sel,
    output logic [ekst_pkg::IDX_W-1:0]       msg_key_idx,
    output logic                             wr_grant
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [ekst_pkg::KEY_W-1:0]  key;
        logic [ekst_pkg::SLOT_W-1:0] slot_idx;
        logic                        src;
        logic                        orig;
        logic                        restr;
        logic                        valid;
        logic [31:0]                 ctrl;
        logic [ekst_pkg::ROLL_N-1:0][ekst_pkg::ROLL_W-1:0] roll;
        logic [31:0]                 rdata;
        logic [ekst_pkg::KEY_W-1:0]  crypt;
        logic [ekst_pkg::SLOT_W-1:0] slot_sel;
        logic [ekst_pkg::IDX_W-1:0]  msg_idx;
        logic                        grant;
    } ekst_state_t;

    ekst_state_t st;       // registered state
    ekst_state_t next_st;  // next state

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // slot used for key lookup: low nibble only
    function automatic logic [ekst_pkg::SLOT_W-1:0]
        slot_of(input logic [ekst_pkg::IDX_W-1:0] idx);
        slot_of = idx[ekst_pkg::SLOT_W-1:0]; // R18
    endfunction

    // any event that wipes working memory
    function automatic logic wipe(input ekst_pkg::ekst_evt_t e);
        wipe = e.sleep | e.brownout | e.wdog | e.tamper;
    endfunction

    // status word; the key itself is never in it
    function automatic logic [31:0] status_of(input ekst_state_t s);
        status_of = 32'h0000_0000;
        status_of[ekst_pkg::ST_VALID] = s.valid;
        status_of[ekst_pkg::ST_SRC]   = s.src;
        status_of[ekst_pkg::ST_ORIG]  = s.orig;
        status_of[ekst_pkg::ST_RESTR] = s.restr;
        status_of[ekst_pkg::ST_SLOT +: ekst_pkg::SLOT_W] = s.slot_idx;
    endfunction

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        logic [ekst_pkg::SLOT_W-1:0] rs;
        logic                        mix;
        rs = slot_of(cmd.key_idx);
        mix = cmd.use_rand & st.ctrl[ekst_pkg::CT_RAND];
        next_st = st;

        // register port: reads answer one cycle later
        next_st.rdata = 32'h0000_0000;
        if (bus.rd) begin
            // key content has no address at all
            if (bus.addr == ekst_pkg::OFS_STATUS) begin
                next_st.rdata = status_of(st); // R2
            end else if (bus.addr == ekst_pkg::OFS_CTRL) begin
                next_st.rdata = st.ctrl;
            end else if (bus.addr >= ekst_pkg::OFS_ROLL0 &&
                         bus.addr <= ekst_pkg::OFS_ROLL7 &&
                         bus.addr[1:0] == 2'b00) begin
                // roll counters, one word each
                next_st.rdata = {24'h00_0000,
                    st.roll[3'((bus.addr - ekst_pkg::OFS_ROLL0) >> 2)]};
            end
        end
        // control write; only the enable bit is stored
        if (bus.wr && bus.addr == ekst_pkg::OFS_CTRL) begin
            next_st.ctrl = 32'h0000_0000;
            next_st.ctrl[ekst_pkg::CT_RAND] = bus.wdata[ekst_pkg::CT_RAND];
        end

        // finished commands update the key state
        if (cmd.done && !cmd.crc_err) begin // R11
            case (cmd.code)
                ekst_pkg::EKST_SEED: begin
                    if (cmd.ok) begin
                        // seed replaces any digest result
                        next_st.key = mix ? (cmd.data ^ rand_num)
                                          : cmd.data; // R1 R13 R14
                        next_st.src = !mix; // R4
                        next_st.orig = 1'b0; // R5
                        next_st.restr = 1'b0; // R6
                        next_st.valid = 1'b1; // R7
                    end else begin
                        next_st.valid = 1'b0; // R12
                    end
                end
                ekst_pkg::EKST_DIGEST: begin
                    if (cmd.ok) begin
                        // 256-bit digest replaces the seed
                        next_st.key = cmd.data; // R1 R13 R15 R17
                        next_st.slot_idx = rs; // R3
                        next_st.orig = 1'b1; // R5
                        next_st.restr = cmd.restricted; // R6
                        next_st.valid = 1'b1; // R7
                    end else begin
                        next_st.valid = 1'b0; // R12
                    end
                end
                ekst_pkg::EKST_COMPARE: begin
                    // a successful copy keeps the key alive
                    next_st.valid = st.valid & cmd.ok & cmd.copy_ok; // R10
                end
                ekst_pkg::EKST_DERIVE: begin
                    // roll only counts with a valid offset loaded
                    if (cmd.ok && cmd.roll && st.valid &&
                        rs < 4'(ekst_pkg::ROLL_N)) begin // R20
                        next_st.roll[3'(rs)] =
                            st.roll[3'(rs)] + 8'h01; // R21
                    end
                    next_st.valid = 1'b0; // R9
                end
                ekst_pkg::EKST_OTHER: begin
                    next_st.valid = 1'b0; // R9
                end
                default: begin
                    // unknown code still counts as a command
                    next_st.valid = 1'b0; // R9
                end
            endcase
        end

        // key lookup and hash index for the command
        if (cmd.done && cmd.code != ekst_pkg::EKST_DIGEST) begin
            next_st.slot_sel = rs; // R18
        end
        if (cmd.done) begin
            next_st.msg_idx = cmd.key_idx; // R19
        end

        // xor crypt, symmetric both ways
        if (crypt_req) begin
            next_st.crypt = crypt_pad ^ crypt_text; // R16
        end

        // encrypted slot write permission
        next_st.grant = wr_req &
            slot_policy_word[ekst_pkg::POL_WR]; // R22

        // sleep and faults win over everything; idle holds
        if (wipe(evt)) begin
            next_st.valid = 1'b0; // R8 R23
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            // power-up: everything invalid
            st.key <= '0;
            st.slot_idx <= 4'h0;
            st.src <= 1'b0;
            st.orig <= 1'b0;
            st.restr <= 1'b0;
            st.valid <= 1'b0; // R8
            st.ctrl <= ekst_pkg::CTRL_RST;
            st.roll <= {ekst_pkg::ROLL_N{ekst_pkg::ROLL_RST}};
            st.rdata <= 32'h0000_0000;
            st.crypt <= '0;
            st.slot_sel <= 4'h0;
            st.msg_idx <= 16'h0000;
            st.grant <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // outputs, all from flip-flops
    // ----------------------------------------
    assign rdata = st.rdata;
    assign ephemeral_key_out = st.key;
    assign key_present = st.valid; // R24
    assign crypt_out = st.crypt;
    assign slot_sel = st.slot_sel;
    assign msg_key_idx = st.msg_idx;
    assign wr_grant = st.grant;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // status read never exposes key bits
    property p_rd_status;
        bus.rd && bus.addr == ekst_pkg::OFS_STATUS |=>
            rdata[31:8] == 24'h00_0000 && rdata[0] == $past(st.valid);
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status leak"); // R2

    // good digest loads key, slot and origin
    property p_digest;
        cmd.done && !cmd.crc_err && cmd.ok &&
        cmd.code == ekst_pkg::EKST_DIGEST && !wipe(evt) |=>
            st.key == $past(cmd.data) && st.orig && st.valid &&
            st.slot_idx == $past(cmd.key_idx[3:0]);
    endproperty
    a_digest: assert property (p_digest) else $error("digest load"); // R3

    // input-only seed sets source flag and clears origin
    property p_seed;
        cmd.done && !cmd.crc_err && cmd.ok && !cmd.use_rand &&
        cmd.code == ekst_pkg::EKST_SEED |=>
            st.src && !st.orig && !st.restr && st.key == $past(cmd.data);
    endproperty
    a_seed: assert property (p_seed) else $error("seed flags"); // R4

    // wipe events clear valid
    property p_wipe;
        wipe(evt) |=> !st.valid;
    endproperty
    a_wipe: assert property (p_wipe) else $error("wipe kept valid"); // R8

    // other commands clear valid
    property p_other;
        cmd.done && !cmd.crc_err && cmd.code == ekst_pkg::EKST_OTHER
            |=> !key_present;
    endproperty
    a_other: assert property (p_other) else $error("other kept valid"); // R9

    // checksum error leaves valid unchanged
    property p_crc;
        cmd.done && cmd.crc_err && !wipe(evt) |=> $stable(st.valid);
    endproperty
    a_crc: assert property (p_crc) else $error("crc changed valid"); // R11

    // failed seed or digest clears valid
    property p_err;
        cmd.done && !cmd.crc_err && !cmd.ok &&
        (cmd.code == ekst_pkg::EKST_SEED ||
         cmd.code == ekst_pkg::EKST_DIGEST) |=> !st.valid;
    endproperty
    a_err: assert property (p_err) else $error("error kept valid"); // R12

    // xor crypt result
    property p_xor;
        crypt_req |=> crypt_out == ($past(crypt_pad) ^ $past(crypt_text));
    endproperty
    a_xor: assert property (p_xor) else $error("xor wrong"); // R16

    // write grant follows policy bit
    property p_grant;
        wr_req ##1 1'b1 |-> wr_grant == $past(slot_policy_word[14]);
    endproperty
    a_grant: assert property (p_grant) else $error("grant wrong"); // R22

    // successful copy keeps a valid key
    property p_copy;
        st.valid && cmd.done && !cmd.crc_err && cmd.ok && cmd.copy_ok &&
        cmd.code == ekst_pkg::EKST_COMPARE && !wipe(evt) |=> st.valid;
    endproperty
    a_copy: assert property (p_copy) else $error("copy dropped"); // R10

    // idle bus cycles read back as zero
    property p_rdata_idle;
        !bus.rd |=> rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle"); // R2

    // key lookup uses the low index nibble
    property p_slot_sel;
        cmd.done && cmd.code != ekst_pkg::EKST_DIGEST |=>
            slot_sel == $past(cmd.key_idx[3:0]);
    endproperty
    a_slot_sel: assert property (p_slot_sel) else $error("slot select wrong"); // R18

    // hash message gets the whole 16-bit index
    property p_msg_idx;
        cmd.done |=> msg_key_idx == $past(cmd.key_idx);
    endproperty
    a_msg_idx: assert property (p_msg_idx) else $error("message index wrong"); // R19

    // roll with a loaded offset bumps the slot counter
    property p_roll;
        cmd.done && !cmd.crc_err && cmd.ok && cmd.roll && st.valid &&
        cmd.code == ekst_pkg::EKST_DERIVE && !cmd.key_idx[3] |=>
            st.roll[$past(cmd.key_idx[2:0])] ==
                8'($past(st.roll[cmd.key_idx[2:0]]) + 8'h01);
    endproperty
    a_roll: assert property (p_roll) else $error("roll count wrong"); // R21

    // no counting without a valid key
    property p_roll_hold;
        cmd.done && cmd.code == ekst_pkg::EKST_DERIVE && !st.valid |=>
            $stable(st.roll);
    endproperty
    a_roll_hold: assert property (p_roll_hold) else $error("roll without key"); // R24

    // derivation uses up the key
    property p_derive_clr;
        cmd.done && !cmd.crc_err && cmd.code == ekst_pkg::EKST_DERIVE |=>
            !st.valid;
    endproperty
    a_derive_clr: assert property (p_derive_clr) else $error("derive kept valid"); // R9

    // compare without a good copy drops the key
    property p_cmp_clr;
        cmd.done && !cmd.crc_err && !(cmd.ok && cmd.copy_ok) &&
        cmd.code == ekst_pkg::EKST_COMPARE |=>
            !st.valid;
    endproperty
    a_cmp_clr: assert property (p_cmp_clr) else $error("compare kept valid"); // R10

    // enabled random mixing clears the source flag
    property p_seed_rand;
        cmd.done && !cmd.crc_err && cmd.ok && cmd.use_rand &&
        st.ctrl[ekst_pkg::CT_RAND] && cmd.code == ekst_pkg::EKST_SEED |=>
            !st.src && st.key == $past(cmd.data ^ rand_num);
    endproperty
    a_seed_rand: assert property (p_seed_rand) else $error("random seed wrong"); // R14

    // idle and quiet cycles keep key and valid
    property p_idle_hold;
        !cmd.done && !wipe(evt) |=> $stable(st.valid) && $stable(st.key);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("key state drifted"); // R8

    // restricted flag follows the digest's keys
    property p_restr;
        cmd.done && !cmd.crc_err && cmd.ok && cmd.code == ekst_pkg::EKST_DIGEST |=>
            st.restr == $past(cmd.restricted);
    endproperty
    a_restr: assert property (p_restr) else $error("restricted flag wrong"); // R6

    // no request, no grant
    property p_grant_low;
        !wr_req |=> !wr_grant;
    endproperty
    a_grant_low: assert property (p_grant_low) else $error("grant without request"); // R22
endmodule

// >>> test/ekst_host_model.sv
// host-side model that hands finished commands to the tracker
`timescale 1ns/100ps
module ekst_host_model (
    input  wire logic           ref_clk,
    output ekst_pkg::ekst_cmd_t cmd
);
    // ----------------------------------------
    // command port
    // ----------------------------------------
    initial cmd = '0;

    // one-cycle done pulse; fields scrambled once done drops
    task automatic issue(input ekst_pkg::ekst_cmd_t c);
        ekst_pkg::ekst_cmd_t idle_c;
        c.done = 1'b1;
        idle_c = ~c;
        idle_c.done = 1'b0;
        @(posedge ref_clk);
        cmd <= c;
        @(posedge ref_clk);
        cmd <= idle_c;
    endtask
endmodule

// >>> test/test_ephemeral_key_state_tracker.sv
// self-checking bench for the ephemeral key tracker
`timescale 1ns/100ps
module test_ephemeral_key_state_tracker;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic                ref_clk = 1'b0;
    logic                rst_b = 1'b0;
    ekst_pkg::ekst_bus_t bus = '0;
    logic [31:0]         rdata;
    ekst_pkg::ekst_cmd_t cmd;
    logic [255:0]        rand_num = {8{32'h0F0F_3C3C}};
    ekst_pkg::ekst_evt_t evt = '0;
    logic                crypt_req = 1'b0;
    logic [255:0]        crypt_pad = '0;
    logic [255:0]        crypt_text = '0;
    logic                wr_req = 1'b0;
    logic [15:0]         slot_policy_word = 16'h0000;
    logic [255:0]        key_out;
    logic [255:0]        crypt_out;
    logic                key_present;
    logic                wr_grant;
    logic [3:0]          slot_sel;
    logic [15:0]         msg_key_idx;
    int                  err_total = 0;
    int                  comparisons = 0;
    localparam logic [255:0] CH = {8{32'hA5C3_0F1E}};
    localparam logic [255:0] DG = {8{32'h1357_9BDF}};

    // 20 MHz clock
    always #25 ref_clk = ~ref_clk;

    ekst_tracker i_ekst_tracker (
        .ref_clk           (ref_clk),
        .rst_b             (rst_b),
        .bus               (bus),
        .rdata             (rdata),
        .cmd               (cmd),
        .rand_num          (rand_num),
        .evt               (evt),
        .crypt_req         (crypt_req),
        .crypt_pad         (crypt_pad),
        .crypt_text        (crypt_text),
        .wr_req            (wr_req),
        .slot_policy_word  (slot_policy_word),
        .ephemeral_key_out (key_out),
        .key_present       (key_present),
        .crypt_out         (crypt_out),
        .slot_sel          (slot_sel),
        .msg_key_idx       (msg_key_idx),
        .wr_grant          (wr_grant)
    );

    ekst_host_model i_ekst_host_model (
        .ref_clk (ref_clk),
        .cmd     (cmd)
    );

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask

    // one-cycle read; data compared under a mask in the following cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge ref_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge ref_clk);
        bus <= '0;
        #1;
        chk("rdata", e & m, rdata & m);
    endtask

    // one-cycle write
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge ref_clk);
        bus <= '0;
    endtask

    // flags are {ok, crc_err, copy_ok, use_rand, restricted, roll}
    task automatic run(input ekst_pkg::ekst_cmd_code_t c, input logic [5:0] f,
                       input logic [15:0] idx, input logic [255:0] dat);
        i_ekst_host_model.issue({1'b0, c, f, idx, dat});
        #1;
    endtask

    // ----------------------------------------
    // watchdog and main sequence
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        stop_test();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(ekst_pkg::OFS_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(ekst_pkg::OFS_CTRL, ekst_pkg::CTRL_RST, 32'hFFFF_FFFF);
        rd(ekst_pkg::OFS_ROLL7, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
        $display("test reset done");
        // seed from input only, then mixed with random
        run(ekst_pkg::EKST_SEED, 6'b100000, 16'h0000, CH);
        chk("key", CH, key_out);
        rd(ekst_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_000F);
        run(ekst_pkg::EKST_SEED, 6'b100100, 16'h0000, CH);
        chk("key", CH ^ rand_num, key_out);
        rd(ekst_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_000F);
        // digest replaces seed
        run(ekst_pkg::EKST_DIGEST, 6'b100010, 16'h1235, DG);
        chk("key", DG, key_out);
        rd(ekst_pkg::OFS_STATUS, 32'h0000_005D, 32'h0000_00FD);
        chk("msg_idx", 16'h1235, msg_key_idx);
        // checksum reject keeps valid
        run(ekst_pkg::EKST_OTHER, 6'b010000, 16'h00A7, CH);
        chk("valid", 1'b1, key_present);
        chk("slot_sel", 4'h7, slot_sel);
        $display("test load done");
        // other commands clear valid whether ok or not; seed and digest errors too
        for (int i = 0; i < 4; i++) begin
            run(ekst_pkg::EKST_SEED, 6'b100000, 16'h0000, CH);
            run((i < 2) ? ekst_pkg::EKST_OTHER : ((i == 2) ? ekst_pkg::EKST_SEED
                : ekst_pkg::EKST_DIGEST), {1'(i == 1), 5'b00000}, 16'h0003, DG);
            chk("valid", 1'b0, key_present);
        end
        // compare keeps valid only after a successful copy
        run(ekst_pkg::EKST_SEED, 6'b100000, 16'h0000, CH);
        run(ekst_pkg::EKST_COMPARE, 6'b101000, 16'h0001, DG);
        chk("valid", 1'b1, key_present);
        run(ekst_pkg::EKST_COMPARE, 6'b100000, 16'h0001, DG);
        chk("valid", 1'b0, key_present);
        $display("test clear done");
        // roll on slot 2 after a seed
        run(ekst_pkg::EKST_SEED, 6'b100000, 16'h0000, CH);
        run(ekst_pkg::EKST_DERIVE, 6'b100001, 16'h0002, DG);
        rd(ekst_pkg::OFS_ROLL0 + 8'h08, 32'h0000_0001, 32'h0000_00FF);
        // a second roll without a fresh seed finds no key and must not count
        run(ekst_pkg::EKST_DERIVE, 6'b100001, 16'h0002, DG);
        rd(ekst_pkg::OFS_ROLL0 + 8'h08, 32'h0000_0001, 32'h0000_00FF);
        // random mixing off, status not writable
        wr(ekst_pkg::OFS_CTRL, 32'h0000_0000);
        wr(ekst_pkg::OFS_STATUS, 32'hFFFF_FFFF);
        run(ekst_pkg::EKST_SEED, 6'b100100, 16'h0000, CH);
        chk("key", CH, key_out);
        rd(ekst_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_000F);
        $display("test roll done");
        // wipe events clear valid, idle keeps it
        for (int i = 0; i < 5; i++) begin
            run(ekst_pkg::EKST_SEED, 6'b100000, 16'h0000, CH);
            @(posedge ref_clk);
            evt <= ekst_pkg::ekst_evt_t'(5'b00001 << i);
            @(posedge ref_clk);
            evt <= '0;
            #1;
            chk("valid", (i == 0), key_present);
        end
        chk("key", CH, key_out);
        // xor crypt
        @(posedge ref_clk);
        crypt_req <= 1'b1;
        crypt_pad <= DG;
        crypt_text <= CH;
        @(posedge ref_clk);
        crypt_req <= 1'b0;
        #1;
        chk("crypt", DG ^ CH, crypt_out);
        // encrypted write grant needs policy bit 14
        for (int i = 0; i < 2; i++) begin
            @(posedge ref_clk);
            wr_req <= 1'b1;
            slot_policy_word <= (i == 0) ? 16'h4000 : 16'hBFFF;
            @(posedge ref_clk);
            wr_req <= 1'b0;
            #1;
            chk("wr_grant", (i == 0), wr_grant);
        end
        $display("test misc done");
        stop_test();
    end
endmodule
